// ---- rtl/fma_irq.sv ----
// sticky event status with enable and write-one-to-clear, one level interrupt
`default_nettype none
module fma_irq #(
  parameter int N = 8
) (
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  input  wire logic [N-1:0] event_i,
  input  wire logic         en_wr_i,
  input  wire logic         clr_wr_i,
  input  wire logic [N-1:0] wdata_i,
  output logic      [N-1:0] status_o,
  output logic      [N-1:0] enable_o,
  output logic              irq_o
);
  // ------------------------------------------------------------------
  // sticky status and enable
  // ------------------------------------------------------------------
  // a new event beats a clear in the same cycle so nothing is lost
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      status_o <= '0;
    end else begin
      status_o <= (status_o & ~(clr_wr_i ? wdata_i : '0)) | event_i;
    end
  end

  // enable register
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      enable_o <= '0;
    end else if (en_wr_i) begin
      enable_o <= wdata_i;
    end
  end

  // level interrupt, handshake-style combinational output
  assign irq_o = |(status_o & enable_o);
endmodule
`default_nettype wire

// ---- rtl/fma_pkg.sv ----
// package for the fault mask and aggregation block: offsets, fields, reset values
`default_nettype none
package fma_pkg;
  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] FMA_ADDR_INTEGRITY = 8'h49;   // integrity_check_mask
  localparam logic [7:0] FMA_ADDR_OVERCUR   = 8'h4a;   // overcurrent_flag_mask
  localparam logic [7:0] FMA_ADDR_OUTPUT    = 8'h4b;   // fault_output_mask
  localparam logic [7:0] FMA_ADDR_IRQ_STAT  = 8'h50;   // sticky event status, read only
  localparam logic [7:0] FMA_ADDR_IRQ_CLR   = 8'h51;   // write one to clear
  localparam logic [7:0] FMA_ADDR_IRQ_EN    = 8'h52;   // interrupt enable
  localparam logic [7:0] FMA_ADDR_CTRL      = 8'h53;   // pin function select
  localparam logic [7:0] FMA_ADDR_SUMMARY   = 8'h54;   // live summary flags, read only

  // ------------------------------------------------------------------
  // writable field masks and reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] FMA_INTEGRITY_WMASK = 16'he800;  // bits 15,14,13,11
  localparam logic [15:0] FMA_OVERCUR_WMASK   = 16'h000f;  // bits 3:0
  localparam logic [15:0] FMA_OUTPUT_WMASK    = 16'h7f80;  // bits 14:7
  localparam logic [15:0] FMA_INTEGRITY_RST   = 16'h0000;
  localparam logic [15:0] FMA_OVERCUR_RST     = 16'h0000;
  localparam logic [15:0] FMA_OUTPUT_RST      = 16'h0780;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int FMA_BIT_SEC1   = 15;
  localparam int FMA_BIT_SEC2   = 14;
  localparam int FMA_BIT_SEC3   = 13;
  localparam int FMA_BIT_MEM    = 11;
  localparam int FMA_BIT_A_HIGH = 3;
  localparam int FMA_BIT_A_LOW  = 2;
  localparam int FMA_BIT_B_HIGH = 1;
  localparam int FMA_BIT_B_LOW  = 0;
  localparam int FMA_OUT_LSB    = 7;   // pin mask bits 14:7 cover flags 7:0
  localparam int FMA_NFLAGS     = 8;
  localparam int FMA_NEVENTS    = 8;

  // summary flag vector order, index = pin mask bit minus FMA_OUT_LSB
  typedef struct packed {
    logic power;        // 7
    logic timing;       // 6
    logic integrity;    // 5
    logic overcurrent;  // 4
    logic checksum;     // 3
    logic timeout;      // 2
    logic clock_count;  // 1
    logic bad_access;   // 0
  } fma_flags_t;

  // raw fault sources that this block masks itself
  typedef struct packed {
    logic sec_one;
    logic sec_two;
    logic sec_three;
    logic memory;
    logic a_high;
    logic a_low;
    logic b_high;
    logic b_low;
  } fma_sources_t;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } fma_req_t;

  // register port answer state
  typedef enum logic [1:0] {
    FMA_RD_IDLE = 2'b01,
    FMA_RD_DATA = 2'b10
  } fma_rd_state_t;
endpackage
`default_nettype wire

// ---- rtl/fma_sync.sv ----
// two-stage synchroniser for a vector of pin-level fault sources
`default_nettype none
module fma_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  // ------------------------------------------------------------------
  // stages
  // ------------------------------------------------------------------
  logic [W-1:0] meta_q;   // first stage, read only by the second

  // first stage catches the pin, second stage feeds the logic
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/fma_top.sv ----
// fault mask and aggregation block of a battery-pack monitor
//
// Behaviour
// - section check masks at 15,14,13 gate integrity
// - bit 11 masks memory check fault
// - mask zero passes, mask one blocks
// - converter a: bit 3 high, bit 2 low
// - converter b: bit 1 high, bit 0 low
// - pin mask 14:11 summary flags, reset clear
// - pin mask 10:7 serial flags, reset set
// - pin mask applies only in fault mode
// - reserved bits always read zero
// - overcurrent mask 0000, pin mask 0780 reset
//
// Implementation choice: strobed register access.
`default_nettype none
module fma_top
  import fma_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // raw fault sources from pins or analog comparators
  input  wire logic        config_section_one_check_flag_i,
  input  wire logic        config_section_two_check_flag_i,
  input  wire logic        config_section_three_check_flag_i,
  input  wire logic        memory_check_flag_i,
  input  wire logic        current_a_high_limit_flag_i,
  input  wire logic        current_a_low_limit_flag_i,
  input  wire logic        current_b_high_limit_flag_i,
  input  wire logic        current_b_low_limit_flag_i,
  // summary flags made elsewhere on this clock
  input  wire logic        power_summary_flag_i,
  input  wire logic        timing_summary_flag_i,
  input  wire logic        serial_checksum_error_flag_i,
  input  wire logic        serial_timeout_flag_i,
  input  wire logic        serial_clock_count_error_flag_i,
  input  wire logic        bad_access_flag_i,
  // general-purpose drive of the shared pin when not in fault mode
  input  wire logic        gp_out_i,
  input  wire logic        gp_oe_i,
  // outputs
  output logic             integrity_summary_flag_o,
  output logic             overcurrent_summary_flag_o,
  output logic             shared_alarm_pin_o,
  output logic             shared_alarm_pin_oe_o,
  output logic             irq_o
);
  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  fma_req_t      req;             // bundled register request
  fma_sources_t  src_raw;         // raw sources before synchronising
  fma_sources_t  src;             // synchronised sources
  fma_flags_t    flags;           // all summary flags for the pin
  logic [15:0]   integ_mask_q;    // integrity_check_mask
  logic [15:0]   ocur_mask_q;     // overcurrent_flag_mask
  logic [15:0]   out_mask_q;      // fault_output_mask
  logic          fault_mode_q;    // shared pin acts as fault output
  logic          integ_d;         // next integrity summary
  logic          ocur_d;          // next overcurrent summary
  logic          pin_d;           // next fault pin level
  logic [7:0]    flags_unmasked;  // flags after pin mask
  logic [7:0]    flags_prev_q;    // last flags, for rising-edge events
  logic [7:0]    irq_status;      // sticky event status
  logic [7:0]    irq_enable;      // event enable
  logic [15:0]   rdata_d;         // read mux result
  fma_rd_state_t rd_state_q;      // read answer phase

  // mask test: one blocks, zero passes
  function automatic logic pass(input logic src_bit, input logic mask_bit);
    pass = src_bit & ~mask_bit;
  endfunction

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign src_raw = '{sec_one: config_section_one_check_flag_i,
                     sec_two: config_section_two_check_flag_i,
                     sec_three: config_section_three_check_flag_i,
                     memory: memory_check_flag_i,
                     a_high: current_a_high_limit_flag_i,
                     a_low: current_a_low_limit_flag_i,
                     b_high: current_b_high_limit_flag_i,
                     b_low: current_b_low_limit_flag_i};

  // ------------------------------------------------------------------
  // source synchroniser
  // ------------------------------------------------------------------
  // sources come from other blocks or pins, so they are resynchronised
  fma_sync #(
    .W (8)
  ) u_sync (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .async_i (src_raw),
    .sync_o  (src)
  );

  // ------------------------------------------------------------------
  // mask registers
  // ------------------------------------------------------------------
  // only defined mask bits are stored; reserved bits stay zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      integ_mask_q <= FMA_INTEGRITY_RST;
    end else if (req.wr && req.addr == FMA_ADDR_INTEGRITY) begin
      integ_mask_q <= req.wdata & FMA_INTEGRITY_WMASK;
    end
  end

  // overcurrent mask register
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ocur_mask_q <= FMA_OVERCUR_RST;
    end else if (req.wr && req.addr == FMA_ADDR_OVERCUR) begin
      ocur_mask_q <= req.wdata & FMA_OVERCUR_WMASK;
    end
  end

  // pin mask register; serial flag masks come up set
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      out_mask_q <= FMA_OUTPUT_RST;
    end else if (req.wr && req.addr == FMA_ADDR_OUTPUT) begin
      out_mask_q <= req.wdata & FMA_OUTPUT_WMASK;
    end
  end

  // pin function select, default general purpose
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      fault_mode_q <= 1'b0;
    end else if (req.wr && req.addr == FMA_ADDR_CTRL) begin
      fault_mode_q <= req.wdata[0];
    end
  end

  // ------------------------------------------------------------------
  // summary aggregation
  // ------------------------------------------------------------------
  always_comb begin
    integ_d = pass(src.sec_one,   integ_mask_q[FMA_BIT_SEC1])
            | pass(src.sec_two,   integ_mask_q[FMA_BIT_SEC2])
            | pass(src.sec_three, integ_mask_q[FMA_BIT_SEC3])
            | pass(src.memory,    integ_mask_q[FMA_BIT_MEM]);
    ocur_d  = pass(src.a_high, ocur_mask_q[FMA_BIT_A_HIGH])
            | pass(src.a_low,  ocur_mask_q[FMA_BIT_A_LOW])
            | pass(src.b_high, ocur_mask_q[FMA_BIT_B_HIGH])
            | pass(src.b_low,  ocur_mask_q[FMA_BIT_B_LOW]);
  end

  // summary flags registered so they are glitch free
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      integrity_summary_flag_o   <= 1'b0;
      overcurrent_summary_flag_o <= 1'b0;
    end else begin
      integrity_summary_flag_o   <= integ_d;
      overcurrent_summary_flag_o <= ocur_d;
    end
  end

  assign flags = '{power: power_summary_flag_i, timing: timing_summary_flag_i,
                   integrity: integrity_summary_flag_o, overcurrent: overcurrent_summary_flag_o,
                   checksum: serial_checksum_error_flag_i, timeout: serial_timeout_flag_i,
                   clock_count: serial_clock_count_error_flag_i, bad_access: bad_access_flag_i};

  // ------------------------------------------------------------------
  // fault pin
  // ------------------------------------------------------------------
  // pin mask only matters in fault mode; otherwise the gpio owns the pin
  always_comb begin
    flags_unmasked = flags & ~out_mask_q[FMA_OUT_LSB +: FMA_NFLAGS];
    pin_d          = fault_mode_q ? |flags_unmasked : gp_out_i;
  end

  // pin data from a flop; enable on in fault mode, else from gp_oe_i
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      shared_alarm_pin_o <= 1'b0;
    end else begin
      shared_alarm_pin_o <= pin_d;
    end
  end

  assign shared_alarm_pin_oe_o = fault_mode_q | gp_oe_i;

  // ------------------------------------------------------------------
  // interrupt events: rising edge of each summary flag
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flags_prev_q <= '0;
    end else begin
      flags_prev_q <= flags;
    end
  end

  fma_irq #(
    .N (FMA_NEVENTS)
  ) u_irq (
    .mclk_i   (mclk_i),
    .srst_i   (srst_i),
    .event_i  (flags & ~flags_prev_q),
    .en_wr_i  (req.wr && req.addr == FMA_ADDR_IRQ_EN),
    .clr_wr_i (req.wr && req.addr == FMA_ADDR_IRQ_CLR),
    .wdata_i  (req.wdata[7:0]),
    .status_o (irq_status),
    .enable_o (irq_enable),
    .irq_o    (irq_o)
  );

  // ------------------------------------------------------------------
  // read port: data stand one cycle after the strobe, zero otherwise
  // ------------------------------------------------------------------
  always_comb begin
    unique case (req.addr)
      FMA_ADDR_INTEGRITY: rdata_d = integ_mask_q;
      FMA_ADDR_OVERCUR:   rdata_d = ocur_mask_q;
      FMA_ADDR_OUTPUT:    rdata_d = out_mask_q;
      FMA_ADDR_IRQ_STAT:  rdata_d = {8'h00, irq_status};
      FMA_ADDR_IRQ_EN:    rdata_d = {8'h00, irq_enable};
      FMA_ADDR_CTRL:      rdata_d = {15'h0000, fault_mode_q};
      FMA_ADDR_SUMMARY:   rdata_d = {8'h00, flags};
      default:            rdata_d = 16'h0000;       // unmapped and clear reg
    endcase
  end

  // read data register, cleared when no read was made
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 16'h0000;
      rd_state_q  <= FMA_RD_IDLE;
    end else begin
      reg_rdata_o <= req.rd ? rdata_d : 16'h0000;
      rd_state_q  <= req.rd ? FMA_RD_DATA : FMA_RD_IDLE;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  property p_integ;
    @(posedge mclk_i) disable iff (srst_i)
    (src.sec_one && !integ_mask_q[FMA_BIT_SEC1]) |=> integrity_summary_flag_o;
  endproperty
  a_integ: assert property (p_integ) else $error("unmasked section check lost");

  property p_mem;
    @(posedge mclk_i) disable iff (srst_i)
    (integ_mask_q[FMA_BIT_MEM] && src.memory && !src.sec_one && !src.sec_two && !src.sec_three)
      |=> !integrity_summary_flag_o;
  endproperty
  a_mem: assert property (p_mem) else $error("masked memory check leaked");

  property p_enc;
    @(posedge mclk_i) disable iff (srst_i)
    (ocur_mask_q[3:0] == 4'hf) |=> !overcurrent_summary_flag_o;
  endproperty
  a_enc: assert property (p_enc) else $error("fully masked overcurrent raised");

  property p_ocur_a;
    @(posedge mclk_i) disable iff (srst_i)
    (src.a_high && !ocur_mask_q[FMA_BIT_A_HIGH]) || (src.a_low && !ocur_mask_q[FMA_BIT_A_LOW])
      |=> overcurrent_summary_flag_o;
  endproperty
  a_ocur_a: assert property (p_ocur_a) else $error("converter a fault lost");

  property p_ocur_b;
    @(posedge mclk_i) disable iff (srst_i)
    (src.b_high && !ocur_mask_q[FMA_BIT_B_HIGH]) || (src.b_low && !ocur_mask_q[FMA_BIT_B_LOW])
      |=> overcurrent_summary_flag_o;
  endproperty
  a_ocur_b: assert property (p_ocur_b) else $error("converter b fault lost");

  property p_pin_or;
    @(posedge mclk_i) disable iff (srst_i)
    fault_mode_q |=> (shared_alarm_pin_o == $past(|(flags & ~out_mask_q[14:7])));
  endproperty
  a_pin_or: assert property (p_pin_or) else $error("fault pin not the masked or");

  property p_gp;
    @(posedge mclk_i) disable iff (srst_i)
    !fault_mode_q |=> (shared_alarm_pin_o == $past(gp_out_i));
  endproperty
  a_gp: assert property (p_gp) else $error("pin mask acted outside fault mode");

  property p_rsvd;
    @(posedge mclk_i) disable iff (srst_i)
    (integ_mask_q & ~16'he800) == 16'h0000 && (ocur_mask_q & ~16'h000f) == 16'h0000
      && (out_mask_q & ~16'h7f80) == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mask bit set");

  property p_rst;
    @(posedge mclk_i) ($past(srst_i) && !srst_i) |-> (out_mask_q == 16'h0780 && ocur_mask_q == 16'h0000);
  endproperty
  a_rst: assert property (p_rst) else $error("mask reset value wrong");

  // read data must be zero whenever no read answer is due
  property p_rdata_idle;
    @(posedge mclk_i) disable iff (srst_i)
    (rd_state_q == FMA_RD_IDLE) |-> (reg_rdata_o == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
endmodule
`default_nettype wire

// ---- sim/fma_host_model.sv ----
// host-side monitor of the shared alarm pin: resolves the line and counts alarms
`default_nettype none
module fma_host_model (
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  input  wire logic       pin_i,
  input  wire logic       oe_i,
  output logic            line_o,
  output logic [7:0]      alarm_cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // line resolution and alarm counting
  // ------------------------------------------------------------------
  logic line_q;  // previous line level for edge detect
  // the host board holds a pull-down, so an undriven line reads low
  assign line_o = oe_i ? pin_i : 1'b0;
  // count rising edges, as an alarm handler would; levels alone would miss repeats
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      line_q      <= 1'b0;
      alarm_cnt_o <= 8'h00;
    end else begin
      line_q <= line_o;
      if (line_o && !line_q) begin
        alarm_cnt_o <= alarm_cnt_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the fault mask and aggregation block
`default_nettype none
module tb
  import fma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] im;   // integrity mask
    logic [15:0] om;   // overcurrent mask
    logic [15:0] pm;   // pin mask
    logic        ctl;  // fault mode
    logic [7:0]  src;  // raw sources
    logic [5:0]  oth;  // power,timing,checksum,timeout,clock count,bad access
    logic        gp;   // gpio drive and enable
    logic        ei;   // expected integrity flag
    logic        eo;   // expected overcurrent flag
    logic        ep;   // expected pin
  } fma_row_t;
  logic         mclk_i    = 1'b0;
  logic         srst_i    = 1'b1;
  logic [7:0]   reg_addr  = 8'h00;
  logic [15:0]  reg_wdata = 16'h0000;
  logic         reg_wr    = 1'b0;
  logic         reg_rd    = 1'b0;
  logic [15:0]  reg_rdata;
  fma_sources_t src       = '0;
  logic [5:0]   oth       = 6'h00;
  logic         gp        = 1'b0;
  logic         int_f, ovc_f, pin, pin_oe, irq, line;
  logic [7:0]   alarms, n0;
  logic [15:0]  rd_v;
  int           errors    = 0;
  int           compares  = 0;
  int           cycles    = 0;
  localparam fma_row_t ROWS [22] = '{
    '{16'h0000, 16'h0000, 16'h0780, 1'b1, 8'h80, 6'h00, 1'b0, 1'b1, 1'b0, 1'b1},
    '{16'h8000, 16'h0000, 16'h0780, 1'b1, 8'h80, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'h8000, 16'h0000, 16'h0780, 1'b1, 8'h40, 6'h00, 1'b0, 1'b1, 1'b0, 1'b1},
    '{16'he000, 16'h0000, 16'h0780, 1'b1, 8'he0, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'he000, 16'h0000, 16'h0780, 1'b1, 8'h10, 6'h00, 1'b0, 1'b1, 1'b0, 1'b1},
    '{16'he800, 16'h0000, 16'h0780, 1'b1, 8'h10, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'h0000, 16'h0008, 16'h0780, 1'b1, 8'h08, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'h0000, 16'h0008, 16'h0780, 1'b1, 8'h04, 6'h00, 1'b0, 1'b0, 1'b1, 1'b1},
    '{16'h0000, 16'h0007, 16'h0780, 1'b1, 8'h0f, 6'h00, 1'b0, 1'b0, 1'b1, 1'b1},
    '{16'h0000, 16'h000e, 16'h0780, 1'b1, 8'h01, 6'h00, 1'b0, 1'b0, 1'b1, 1'b1},
    '{16'h0000, 16'h000f, 16'h0780, 1'b1, 8'h0f, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'h0000, 16'h0000, 16'h0780, 1'b1, 8'h00, 6'h08, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'h0000, 16'h0000, 16'h0000, 1'b1, 8'h00, 6'h08, 1'b0, 1'b0, 1'b0, 1'b1},
    '{16'h0000, 16'h0000, 16'h0000, 1'b1, 8'h00, 6'h01, 1'b0, 1'b0, 1'b0, 1'b1},
    '{16'h0000, 16'h0000, 16'h4000, 1'b1, 8'h00, 6'h20, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'h0000, 16'h0000, 16'h2000, 1'b1, 8'h00, 6'h10, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'h0000, 16'h0000, 16'h0800, 1'b1, 8'h08, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0},
    '{16'h0000, 16'h0000, 16'h1000, 1'b1, 8'h80, 6'h00, 1'b0, 1'b1, 1'b0, 1'b0},
    '{16'h0000, 16'h0000, 16'h0000, 1'b0, 8'h00, 6'h3f, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'h0000, 16'h0000, 16'h7f80, 1'b0, 8'h00, 6'h00, 1'b1, 1'b0, 1'b0, 1'b1},
    '{16'h0000, 16'h0000, 16'h7980, 1'b1, 8'h00, 6'h04, 1'b0, 1'b0, 1'b0, 1'b1},
    '{16'h0000, 16'h0000, 16'h0700, 1'b1, 8'h00, 6'h02, 1'b0, 1'b0, 1'b0, 1'b0}
  };
  // ------------------------------------------------------------------
  // design, host and clock
  // ------------------------------------------------------------------
  fma_top u_fma_top (
    .mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .config_section_one_check_flag_i(src.sec_one), .config_section_two_check_flag_i(src.sec_two),
    .config_section_three_check_flag_i(src.sec_three), .memory_check_flag_i(src.memory),
    .current_a_high_limit_flag_i(src.a_high), .current_a_low_limit_flag_i(src.a_low),
    .current_b_high_limit_flag_i(src.b_high), .current_b_low_limit_flag_i(src.b_low),
    .power_summary_flag_i(oth[5]), .timing_summary_flag_i(oth[4]),
    .serial_checksum_error_flag_i(oth[3]), .serial_timeout_flag_i(oth[2]),
    .serial_clock_count_error_flag_i(oth[1]), .bad_access_flag_i(oth[0]),
    .gp_out_i(gp), .gp_oe_i(gp), .integrity_summary_flag_o(int_f),
    .overcurrent_summary_flag_o(ovc_f), .shared_alarm_pin_o(pin),
    .shared_alarm_pin_oe_o(pin_oe), .irq_o(irq)
  );
  fma_host_model u_fma_host_model (
    .mclk_i(mclk_i), .srst_i(srst_i), .pin_i(pin), .oe_i(pin_oe), .line_o(line), .alarm_cnt_o(alarms)
  );
  always #10 mclk_i = ~mclk_i;
  // hang guard: the whole sequence needs under a thousand cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // each bus task starts one edge late so a strobe is never set twice at one edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
    check(rd_v, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic reset_dut(input int n);
    @(posedge mclk_i);
    srst_i <= 1'b1;
    repeat (n) @(posedge mclk_i);
    srst_i <= 1'b0;
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    reset_dut(20);
    // masking table: sources and flags against all mask registers
    foreach (ROWS[i]) begin
      wr(FMA_ADDR_INTEGRITY, ROWS[i].im);
      wr(FMA_ADDR_OVERCUR, ROWS[i].om);
      wr(FMA_ADDR_OUTPUT, ROWS[i].pm);
      wr(FMA_ADDR_CTRL, {15'h0000, ROWS[i].ctl});
      @(posedge mclk_i);
      src <= ROWS[i].src;
      oth <= ROWS[i].oth;
      gp  <= ROWS[i].gp;
      settle(6);
      check(16'(int_f), 16'(ROWS[i].ei));
      check(16'(ovc_f), 16'(ROWS[i].eo));
      check(16'(pin), 16'(ROWS[i].ep));
      check(16'(pin_oe), 16'(ROWS[i].ctl | ROWS[i].gp));
    end
    // reset in mid-run brings back the reset value of the control and mask registers
    @(posedge mclk_i);
    src <= '0;
    oth <= 6'h00;
    gp  <= 1'b0;
    wr(FMA_ADDR_INTEGRITY, 16'he800);
    wr(FMA_ADDR_OVERCUR, 16'h000f);
    wr(FMA_ADDR_OUTPUT, 16'h0000);
    reset_dut(2);
    rd_chk(FMA_ADDR_CTRL, 16'h0000);
    rd_chk(FMA_ADDR_INTEGRITY, 16'h0000);
    rd_chk(FMA_ADDR_OVERCUR, 16'h0000);
    rd_chk(FMA_ADDR_OUTPUT, 16'h0780);
    check(16'(pin), 16'h0000);
    // reserved positions drop written ones; unmapped place reads zero
    wr(FMA_ADDR_INTEGRITY, 16'hffff);
    wr(FMA_ADDR_OVERCUR, 16'hffff);
    wr(FMA_ADDR_OUTPUT, 16'hffff);
    wr(8'h7e, 16'hffff);
    rd_chk(FMA_ADDR_INTEGRITY, 16'he800);
    rd_chk(FMA_ADDR_OVERCUR, 16'h000f);
    rd_chk(FMA_ADDR_OUTPUT, 16'h7f80);
    rd_chk(8'h7e, 16'h0000);
    // interrupt raised, masked, held sticky, cleared; host sees one alarm
    wr(FMA_ADDR_OUTPUT, 16'h0000);
    wr(FMA_ADDR_CTRL, 16'h0001);
    wr(FMA_ADDR_IRQ_CLR, 16'h00ff);
    wr(FMA_ADDR_IRQ_EN, 16'h0001);
    n0 = alarms;
    @(posedge mclk_i);
    oth <= 6'h01;
    settle(4);
    check(16'(irq), 16'h0001);
    check(16'(line), 16'h0001);
    check(16'(alarms), 16'(n0 + 8'h01));
    rd_chk(FMA_ADDR_IRQ_STAT, 16'h0001);
    rd_chk(FMA_ADDR_IRQ_EN, 16'h0001);
    rd_chk(FMA_ADDR_SUMMARY, 16'h0001);
    wr(FMA_ADDR_IRQ_EN, 16'h0000);
    settle(1);
    check(16'(irq), 16'h0000);
    wr(FMA_ADDR_IRQ_EN, 16'h0001);
    @(posedge mclk_i);
    oth <= 6'h00;
    settle(4);
    check(16'(irq), 16'h0001);
    wr(FMA_ADDR_IRQ_CLR, 16'h0001);
    settle(1);
    check(16'(irq), 16'h0000);
    rd_chk(FMA_ADDR_IRQ_STAT, 16'h0000);
    rd_chk(FMA_ADDR_IRQ_CLR, 16'h0000);
    // an event landing in the same cycle as its own clear must stay set
    @(posedge mclk_i);
    reg_addr  <= FMA_ADDR_IRQ_CLR;
    reg_wdata <= 16'h0001;
    reg_wr    <= 1'b1;
    oth       <= 6'h01;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
    settle(1);
    check(16'(irq), 16'h0001);
    complete_run();
  end
endmodule
`default_nettype wire
